// ===== tb/mcc_checker.sv
`timescale 1ns/100ps
module mcc_checker (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic i_integrating,
  input wire logic o_light_drive_pos,
  input wire logic o_light_drive_neg,
  input wire logic o_demod,
  input wire mcc_pkg::mcc_trim_t o_trim
);
  // ----
  // Shadow of light level, demod level and freeze, taken from bus writes.
  // ----
  logic [2:0] sh;
  logic wr;
  logic fz;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  assign fz = i_integrating && sh[0];
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sh <= 3'h0;
    end else if (wr && i_paddr == 8'h3c) begin
      sh <= i_pwdata[20:18];
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Three frozen cycles with steady settings let the output lag settle.
  sequence s_frz;
    (fz && $stable(sh))[*3];
  endsequence
  AST_TRIM_COMPL: assert property (o_trim.neg == -o_trim.pos)
    else $error("trim halves not opposite");
  AST_TRIM_DIR: assert property (wr && i_paddr == 8'h38 |-> ##2
    o_trim.pos[4] == ($past(i_pwdata[17], 2) && $past(i_pwdata[16:13], 2) != 0))
    else $error("trim sign wrong");
  AST_TRIM_STEPS: assert property (wr && i_paddr == 8'h38 |-> ##2
    (o_trim.pos[4] ? -o_trim.pos : o_trim.pos) == $past(i_pwdata[16:13], 2))
    else $error("trim size wrong");
  AST_FRZ_POS: assert property (s_frz |-> o_light_drive_pos == sh[2])
    else $error("pos not idle");
  AST_FRZ_NEG: assert property (s_frz |-> o_light_drive_neg == sh[2])
    else $error("neg not idle");
  AST_FRZ_DEMOD: assert property (s_frz |-> o_demod == sh[1])
    else $error("demod not idle");
  AST_FRZ_HOLD: assert property (s_frz |=> fz |-> $stable(o_demod))
    else $error("frozen demod moved");
  AST_RSV_READ: assert property (o_pready && !i_pwrite &&
    i_paddr == 8'h38 |-> o_prdata[31:18] == 0 && o_prdata[12:0] == 0)
    else $error("reserved trim bits set");
  cover property (s_frz);
  cover property (wr && i_paddr == 8'h38);
  cover property (o_pready && !i_pwrite);
endmodule
bind mcc_modulation_clock_config mcc_checker mcc_checker_i (.*);

// ===== tb/mcc_emitter.sv
`timescale 1ns/100ps
module mcc_emitter (
  // Drive and measurement
  input wire logic i_clk,
  input wire logic i_pos,
  output int o_period = 0
);
  // The emitter only sees edges, so period is rising edge to rising edge.
  int cnt = 0;
  logic last = 1'b0;
  always @(posedge i_clk) begin
    last <= i_pos;
    cnt <= (i_pos && !last) ? 1 : cnt + 1;
    if (i_pos && !last) o_period <= cnt;
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, integ = 0;
  logic [7:0] paddr = 0, qcl = 8'h4;
  logic [31:0] pwdata = 0, rd, prdata, d;
  logic serr, rdy, slverr, pos, neg, dem;
  mcc_pkg::mcc_osc_t osc;
  mcc_pkg::mcc_trim_t trim;
  int period, mismatches = 0, compares = 0, seed = 32'h0571, q, p, s;
  mcc_modulation_clock_config mcc_modulation_clock_config_i (
    .i_ref_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy),
    .o_pslverr(slverr), .i_quad_count_limit(qcl), .i_integrating(integ),
    .o_light_drive_pos(pos), .o_light_drive_neg(neg), .o_demod(dem),
    .o_osc_cfg(osc), .o_trim(trim));
  mcc_emitter mcc_emitter_i (.i_clk(clk), .i_pos(pos), .o_period(period));
  initial forever #10 clk = ~clk;
  // ----
  // Checking and bus tasks.
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // An idle edge follows each transfer so no strobe is driven twice at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prdata;
    serr = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) chk(0, 1);
  endtask
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(0, 8'h30, 0);
    chk(rd, 32'h100000);
    apb(0, 8'h3c, 0);
    chk(rd, 32'h499);
    apb(0, 8'h14, 0);
    chk(serr, 1);
    $display("test reset done");
    repeat (8) begin
      s = {$random(seed)} % 24;
      d = (32'(s / 12) << 17) | (32'(s % 12) << 13);
      apb(1, 8'h38, d);
      apb(0, 8'h38, 0);
      chk(rd, d);
      chk(trim.pos, s < 12 ? s % 12 : -(s % 12));
      chk(trim.neg, s < 12 ? -(s % 12) : s % 12);
    end
    $display("test trim done");
    apb(1, 8'h30, 32'h140000);
    apb(0, 8'h40, 0);
    chk(rd, 32'h800000 | 20 * 24000);
    repeat (4) begin
      q = 4 + {$random(seed)} % 8;
      p = {$random(seed)} % 4;
      qcl <= 8'(q);
      apb(1, 8'h3c, 32'h489 | p << 4);
      apb(1, 8'h08, 32'h4);
      apb(1, 8'h08, 0);
      repeat (150) @(posedge clk);
      chk(osc.mult_int, 6'h14);
      chk(osc.prescale, p);
      chk(period, q * (1 + p));
      chk(neg, !pos);
    end
    $display("test period done");
    integ <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h3c, 32'h40489 | k << 19);
      repeat (3) @(posedge clk);
      chk(pos, k / 2);
      chk(neg, k / 2);
      chk(dem, k % 2);
    end
    $display("test freeze done");
    summarize();
  end
endmodule

// ===== verilog/mcc_modulation_clock_config.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "mcc_params.svh"
module mcc_modulation_clock_config #(
  parameter int QCL_W = 8
) (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Timing generator
  input wire logic [QCL_W-1:0] i_quad_count_limit,
  input wire logic i_integrating,
  // Waveforms and settings
  output logic o_light_drive_pos,
  output logic o_light_drive_neg,
  output logic o_demod,
  output mcc_pkg::mcc_osc_t o_osc_cfg,
  output mcc_pkg::mcc_trim_t o_trim
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [23:0] apply_reg;
  logic [23:0] mult;
  logic [23:0] trim;
  logic [23:0] ctrl;
  logic apply_prev;
  logic osc_in_range;
  logic [39:0] osc_khz;
  logic [5:0] idx;
  logic setup;
  logic mapped;
  logic [23:0] rdata;

  assign idx = i_paddr[7:2];
  assign setup = i_psel && !i_penable;

  always_comb begin
    mapped = 1'b1;
    rdata = 24'h000000;
    unique case (idx)
      `MCC_IDX_APPLY: rdata = apply_reg;
      `MCC_IDX_MULT: rdata = mult;
      `MCC_IDX_TRIM: rdata = trim;
      `MCC_IDX_CTRL: rdata = ctrl;
      `MCC_IDX_STATUS: rdata = {osc_in_range, osc_khz[22:0]};
      default: mapped = 1'b0;
    endcase
  end

  // No wait states: the answer comes in the access phase's first cycle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (i_ce) begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup && !i_pwrite && mapped) begin
        o_prdata <= {8'h00, rdata};
      end else if (setup) begin
        o_prdata <= 32'h00000000;
      end
    end
  end

  // Writes land at the completing edge; reserved bits other than control bits 17 to 7 and 3 to 2 never store.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      apply_reg <= 24'h000000;
      mult <= `MCC_RST_MULT;
      trim <= `MCC_RST_TRIM;
      ctrl <= `MCC_RST_CTRL;
    end else if (i_ce && i_psel && i_penable && o_pready && i_pwrite) begin
      unique case (idx)
        `MCC_IDX_APPLY: apply_reg <= i_pwdata[23:0] & `MCC_MASK_APPLY;
        `MCC_IDX_MULT: mult <= i_pwdata[23:0] & `MCC_MASK_MULT; // see (RULE13)
        `MCC_IDX_TRIM: trim <= i_pwdata[23:0] & `MCC_MASK_TRIM; // see (RULE13)
        `MCC_IDX_CTRL: ctrl <= i_pwdata[23:0] & `MCC_MASK_CTRL; // see (RULE13)
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Oscillator settings
  // ---------------------------------------------------------------
  // New settings take effect only on the one-then-zero apply sequence,
  // so a half-written set never reaches the divider.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      apply_prev <= 1'b0;
      o_osc_cfg <= '0;
    end else if (i_ce) begin
      apply_prev <= apply_reg[`MCC_APPLY_BIT];
      if (apply_prev && !apply_reg[`MCC_APPLY_BIT]) begin // see (RULE3)
        o_osc_cfg.mult_int <= mult[`MCC_MINT_HI:`MCC_MINT_LO];
        o_osc_cfg.mult_frac <= mult[`MCC_MFRAC_HI:`MCC_MFRAC_LO];
        o_osc_cfg.post_exp <= ctrl[`MCC_N_HI:`MCC_N_LO];
        o_osc_cfg.prescale <= ctrl[`MCC_PS_HI:`MCC_PS_LO];
      end
    end
  end

  // Oscillator rate from the programmed fields, shown in status so that
  // software can check its choice; an exponent of zero doubles the rate.
  logic [39:0] osc_full;
  assign osc_full = {18'h00000, mult[21:0]} * `MCC_REF_KHZ;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      osc_khz <= 40'h0000000000;
      osc_in_range <= 1'b0;
    end else if (i_ce) begin
      if (ctrl[`MCC_N_HI:`MCC_N_LO] == 2'h0) begin
        osc_khz <= osc_full >> (`MCC_FRAC_BITS - 1);
      end else begin
        osc_khz <= osc_full >> (`MCC_FRAC_BITS - 1
                   + int'(ctrl[`MCC_N_HI:`MCC_N_LO]));
      end
      osc_in_range <= (osc_khz > `MCC_OSC_MIN_KHZ) &&
                      (osc_khz < `MCC_OSC_MAX_KHZ); // see (RULE1)
    end
  end

  // ---------------------------------------------------------------
  // Modulation divider
  // ---------------------------------------------------------------
  // The reference clock stands in for the oscillator; the divide chain is
  // quad limit times (1 + prescale), the analog oscillator does the rest.
  logic [QCL_W+3:0] period;
  logic [QCL_W+3:0] phase;
  logic mod_wave;
  assign period = (QCL_W+4)'(i_quad_count_limit) *
                  (QCL_W+4)'({1'b0, o_osc_cfg.prescale} + 4'h1); // see (RULE2) (RULE14)

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      phase <= '0;
      mod_wave <= 1'b0;
    end else if (i_ce) begin
      if (period == '0 || phase >= period - 1'b1) begin
        phase <= '0;
      end else begin
        phase <= phase + 1'b1;
      end
      mod_wave <= (phase < (period >> 1)); // see (RULE2)
    end
  end

  // ---------------------------------------------------------------
  // Outputs: freeze and duty trim
  // ---------------------------------------------------------------
  logic frozen;
  logic [4:0] steps;
  assign frozen = ctrl[`MCC_FREEZE_BIT] && i_integrating; // see (RULE8)
  assign steps = {1'b0, trim[`MCC_STEPS_HI:`MCC_STEPS_LO]}; // see (RULE6)

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_light_drive_pos <= 1'b0;
      o_light_drive_neg <= 1'b0;
      o_demod <= 1'b0;
    end else if (i_ce) begin
      if (frozen) begin
        o_light_drive_pos <= ctrl[`MCC_LIGHT_POL_BIT]; // see (RULE9)
        o_light_drive_neg <= ctrl[`MCC_LIGHT_POL_BIT]; // see (RULE9)
        o_demod <= ctrl[`MCC_DEMOD_POL_BIT]; // see (RULE10)
      end else begin
        o_light_drive_pos <= mod_wave;
        o_light_drive_neg <= !mod_wave;
        o_demod <= mod_wave;
      end
    end
  end

  // Positive trim lengthens the high time of the positive drive.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_trim <= '0;
    end else if (i_ce) begin
      if (trim[`MCC_DIR_BIT]) begin // see (RULE4)
        o_trim.pos <= -steps;
        o_trim.neg <= steps; // see (RULE5)
      end else begin
        o_trim.pos <= steps;
        o_trim.neg <= -steps; // see (RULE5)
      end
    end
  end

endmodule

// ===== verilog/mcc_params.svh
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH
// Functional notes
// (RULE1) Software keeps multiplier times 24 MHz over 2^(exponent-1) in 300-600 MHz.
// (RULE2) Modulation rate is oscillator rate over quad limit and (1 + prescale).
// (RULE3) Software sets the apply bit to one then zero to activate new settings.
// (RULE4) Trim direction zero lengthens positive drive high time, one shortens it.
// (RULE5) Negative drive receives the opposite trim of the positive drive.
// (RULE6) Trim steps field sets the correction in roughly 360 ps steps.
// (RULE7) Software never programs trim steps above 0Bh, about 4 ns total.
// (RULE8) Freeze holds modulation and demodulation static during integration.
// (RULE9) While frozen, both light drive pins sit at the light idle level.
// (RULE10) While frozen, demodulation sits at the demod idle level.
// (RULE11) Software writes 9 into control bits 17 to 7.
// (RULE12) Software writes 2 into control bits 3 to 2.
// (RULE13) Other reserved bits are written zero and read back zero.
// (RULE14) Quad count limit arrives as an input from the timing generator.

// Register indices; the byte address is four times the index.
`define MCC_IDX_APPLY 6'h02
`define MCC_IDX_MULT 6'h0c
`define MCC_IDX_TRIM 6'h0e
`define MCC_IDX_CTRL 6'h0f
`define MCC_IDX_STATUS 6'h10

// Reset values and writable masks.
`define MCC_RST_MULT 24'h100000
`define MCC_RST_TRIM 24'h000000
`define MCC_RST_CTRL 24'h000499
`define MCC_MASK_APPLY 24'h000004
`define MCC_MASK_MULT 24'h3fffff
`define MCC_MASK_TRIM 24'h03e000
`define MCC_MASK_CTRL 24'h1fffff

// Field positions.
`define MCC_APPLY_BIT 2
`define MCC_MINT_HI 21
`define MCC_MINT_LO 16
`define MCC_MFRAC_HI 15
`define MCC_MFRAC_LO 0
`define MCC_DIR_BIT 17
`define MCC_STEPS_HI 16
`define MCC_STEPS_LO 13
`define MCC_LIGHT_POL_BIT 20
`define MCC_DEMOD_POL_BIT 19
`define MCC_FREEZE_BIT 18
`define MCC_PS_HI 6
`define MCC_PS_LO 4
`define MCC_N_HI 1
`define MCC_N_LO 0

// Oscillator figures, in kHz, and the multiplier fraction width.
`define MCC_REF_KHZ 40'd24000
`define MCC_OSC_MIN_KHZ 40'd300000
`define MCC_OSC_MAX_KHZ 40'd600000
`define MCC_FRAC_BITS 16
`endif

// ===== verilog/mcc_pkg.sv
package mcc_pkg;
  // Active oscillator and divider settings.
  typedef struct packed {
    logic [5:0] mult_int;
    logic [15:0] mult_frac;
    logic [1:0] post_exp;
    logic [2:0] prescale;
  } mcc_osc_t;

  // Signed duty trim for the positive and negative drive delay lines.
  typedef struct packed {
    logic signed [4:0] pos;
    logic signed [4:0] neg;
  } mcc_trim_t;
endpackage
